// >>> logic/scbu_pkg.sv
// package: opcodes, flag positions, reset values for the shift and carry-branch unit
// Overview of operation
// - memory shift-left moves bits up, bit 0 gets zero, old bit 7 to carry
// - accumulator A shift-left: zero into bit 0, old bit 7 into carry
// - accumulator B shift-left: zero into bit 0, old bit 7 into carry
// - double accumulator shift-left: 16-bit shift, carry from old bit 15
// - negative equals result msb; zero set only when whole result is zero
// - overflow equals negative xor carry after every shift
// - memory shift-left carry is the operand's old bit 7
// - memory arithmetic shift-right keeps bit 7, old bit 0 to carry
// - accumulator A arithmetic shift-right keeps sign, carry from old bit 0
// - accumulator B arithmetic shift-right keeps sign, carry from old bit 0
// - memory arithmetic shift-right carry is the operand's old bit 0
// - memory shifts accept extended and all indexed forms, one opcode each
package scbu_pkg;
    localparam logic [7:0] SCBU_OP_SHL_MEM_EXT = 8'h78;
    localparam logic [7:0] SCBU_OP_SHL_MEM_IDX = 8'h68;
    localparam logic [7:0] SCBU_OP_SAR_MEM_EXT = 8'h77;
    localparam logic [7:0] SCBU_OP_SAR_MEM_IDX = 8'h67;
    localparam logic [7:0] SCBU_OP_SHL_A       = 8'h48;
    localparam logic [7:0] SCBU_OP_SHL_B       = 8'h58;
    localparam logic [7:0] SCBU_OP_SHL_D       = 8'h59;
    localparam logic [7:0] SCBU_OP_SAR_A       = 8'h47;
    localparam logic [7:0] SCBU_OP_SAR_B       = 8'h57;
    localparam logic [7:0] SCBU_OP_BR_NC       = 8'h24;
    localparam int         SCBU_FLAG_C      = 0;
    localparam int         SCBU_FLAG_V      = 1;
    localparam int         SCBU_FLAG_Z      = 2;
    localparam int         SCBU_FLAG_N      = 3;
    localparam logic [7:0] SCBU_FLAGS_RST   = 8'hD0;
    localparam logic [15:0] SCBU_PC_STEP    = 16'h0002;
    localparam logic [15:0] SCBU_WORD_RST   = 16'h0000;
    typedef enum logic [3:0] {
        SCBU_NONE   = 4'b0000,
        SCBU_SHL_M  = 4'b0001,
        SCBU_SHL_A  = 4'b0010,
        SCBU_SHL_B  = 4'b0011,
        SCBU_SHL_D  = 4'b0100,
        SCBU_SAR_M  = 4'b0101,
        SCBU_SAR_A  = 4'b0110,
        SCBU_SAR_B  = 4'b0111,
        SCBU_BRNC   = 4'b1000
    } scbu_op_t;
endpackage

// >>> logic/scbu_shifter.sv
// shifter: one-place shift of 8 or 16 bits with N Z V C flags
`timescale 1ns/1ns
module scbu_shifter
    import scbu_pkg::*;
(
    input  wire logic [15:0] operand,
    input  wire logic        wide,
    input  wire logic        right,
    output logic      [15:0] result,
    output logic             flag_n,
    output logic             flag_z,
    output logic             flag_v,
    output logic             flag_c
);
    always_comb begin
        if (right) begin
            // byte arithmetic right: sign bit held
            result = {8'h00, operand[7], operand[7:1]};
            flag_c = operand[0];
        end else if (wide) begin
            result = {operand[14:0], 1'b0};
            flag_c = operand[15];
        end else begin
            result = {8'h00, operand[6:0], 1'b0};
            flag_c = operand[7];
        end
        flag_n = wide ? result[15] : result[7];
        flag_z = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
        flag_v = flag_n ^ flag_c;
    end
endmodule

// >>> logic/scbu_core.sv
// core: opcode decode, accumulator and flag update, carry-clear branch
`timescale 1ns/1ns
module scbu_core
    import scbu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        exec_valid,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  mem_data_in,
    input  wire logic [7:0]  rel_offset,
    input  wire logic [15:0] pc_in,
    input  wire logic        load_valid,
    input  wire logic [7:0]  load_acc_a,
    input  wire logic [7:0]  load_acc_b,
    input  wire logic [7:0]  load_flags,
    output logic      [7:0]  acc_a,
    output logic      [7:0]  acc_b,
    output logic      [7:0]  condition_flags,
    output logic      [7:0]  mem_data_out,
    output logic             mem_write,
    output logic      [15:0] pc_out,
    output logic             pc_load,
    output logic             illegal_op
);
    logic [7:0]  acc_a_q, acc_a_d, acc_b_q, acc_b_d, flags_q, flags_d;
    logic [7:0]  mem_q, mem_d;
    logic        mem_wr_q, mem_wr_d, pc_ld_q, pc_ld_d, ill_q, ill_d;
    logic [15:0] pc_q, pc_d, sh_in, sh_out;
    logic        sh_wide, sh_right, fn, fz, fv, fc;
    scbu_op_t    op;

    // one decoder serves operand select and the commit path
    function automatic scbu_op_t decode(input logic [7:0] code);
        if (code == SCBU_OP_SHL_MEM_EXT || code == SCBU_OP_SHL_MEM_IDX) begin
            decode = SCBU_SHL_M;
        end else if (code == SCBU_OP_SAR_MEM_EXT || code == SCBU_OP_SAR_MEM_IDX) begin
            decode = SCBU_SAR_M;
        end else if (code == SCBU_OP_SHL_A) begin
            decode = SCBU_SHL_A;
        end else if (code == SCBU_OP_SHL_B) begin
            decode = SCBU_SHL_B;
        end else if (code == SCBU_OP_SHL_D) begin
            decode = SCBU_SHL_D;
        end else if (code == SCBU_OP_SAR_A) begin
            decode = SCBU_SAR_A;
        end else if (code == SCBU_OP_SAR_B) begin
            decode = SCBU_SAR_B;
        end else if (code == SCBU_OP_BR_NC) begin
            decode = SCBU_BRNC;
        end else begin
            decode = SCBU_NONE;
        end
    endfunction

    assign op = decode(opcode);

    always_comb begin
        sh_wide  = (op == SCBU_SHL_D);
        sh_right = (op == SCBU_SAR_M) || (op == SCBU_SAR_A) || (op == SCBU_SAR_B);
        case (op)
            SCBU_SHL_A, SCBU_SAR_A: sh_in = {8'h00, acc_a_q};
            SCBU_SHL_B, SCBU_SAR_B: sh_in = {8'h00, acc_b_q};
            SCBU_SHL_D:             sh_in = {acc_a_q, acc_b_q};
            default:                sh_in = {8'h00, mem_data_in};
        endcase
    end

    scbu_shifter u_shift (
        .operand (sh_in),
        .wide    (sh_wide),
        .right   (sh_right),
        .result  (sh_out),
        .flag_n  (fn),
        .flag_z  (fz),
        .flag_v  (fv),
        .flag_c  (fc)
    );

    always_comb begin
        acc_a_d  = acc_a_q;
        acc_b_d  = acc_b_q;
        flags_d  = flags_q;
        mem_d    = mem_q;
        mem_wr_d = 1'b0;
        pc_d     = pc_q;
        pc_ld_d  = 1'b0;
        ill_d    = 1'b0;
        if (load_valid) begin
            acc_a_d = load_acc_a;
            acc_b_d = load_acc_b;
            flags_d = load_flags;
        end else if (exec_valid) begin
            // only N Z V C are rewritten, upper four flags ride through
            if (op != SCBU_NONE && op != SCBU_BRNC) begin
                flags_d[SCBU_FLAG_N] = fn;
                flags_d[SCBU_FLAG_Z] = fz;
                flags_d[SCBU_FLAG_V] = fv;
                flags_d[SCBU_FLAG_C] = fc;
            end
            case (op)
                SCBU_SHL_M, SCBU_SAR_M: begin
                    mem_d    = sh_out[7:0];
                    mem_wr_d = 1'b1;
                end
                SCBU_SHL_A, SCBU_SAR_A: acc_a_d = sh_out[7:0];
                SCBU_SHL_B, SCBU_SAR_B: acc_b_d = sh_out[7:0];
                SCBU_SHL_D: begin
                    acc_a_d = sh_out[15:8];
                    acc_b_d = sh_out[7:0];
                end
                SCBU_BRNC: begin
                    // flags untouched; offset sign-extended before the add
                    pc_ld_d = 1'b1;
                    if (!flags_q[SCBU_FLAG_C]) begin
                        pc_d = pc_in + SCBU_PC_STEP + {{8{rel_offset[7]}}, rel_offset};
                    end else begin
                        pc_d = pc_in + SCBU_PC_STEP;
                    end
                end
                default: ill_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_a_q  <= 8'h00;
            acc_b_q  <= 8'h00;
            flags_q  <= SCBU_FLAGS_RST;
            mem_q    <= 8'h00;
            mem_wr_q <= 1'b0;
            pc_q     <= SCBU_WORD_RST;
            pc_ld_q  <= 1'b0;
            ill_q    <= 1'b0;
        end else begin
            acc_a_q  <= acc_a_d;
            acc_b_q  <= acc_b_d;
            flags_q  <= flags_d;
            mem_q    <= mem_d;
            mem_wr_q <= mem_wr_d;
            pc_q     <= pc_d;
            pc_ld_q  <= pc_ld_d;
            ill_q    <= ill_d;
        end
    end

    assign acc_a           = acc_a_q;
    assign acc_b           = acc_b_q;
    assign condition_flags = flags_q;
    assign mem_data_out    = mem_q;
    assign mem_write       = mem_wr_q;
    assign pc_out          = pc_q;
    assign pc_load         = pc_ld_q;
    assign illegal_op      = ill_q;
endmodule

// >>> bench/scbu_core_chk.sv
// checker: result and flag relations of the shift and carry-branch core
`timescale 1ns/1ns
module scbu_core_chk
    import scbu_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        exec_valid,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  mem_data_in,
    input wire logic [7:0]  rel_offset,
    input wire logic [15:0] pc_in,
    input wire logic        load_valid,
    input wire logic [7:0]  acc_a,
    input wire logic [7:0]  acc_b,
    input wire logic [7:0]  condition_flags,
    input wire logic [7:0]  mem_data_out,
    input wire logic        mem_write,
    input wire logic [15:0] pc_out,
    input wire logic        pc_load
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] f;
    logic       go;
    logic       sh;
    assign f = condition_flags;
    // a load wins over execution, so it must not arm any check
    assign go = exec_valid && !load_valid;
    assign sh = go && opcode inside {8'h78, 8'h68, 8'h77, 8'h67, 8'h48, 8'h58, 8'h59, 8'h47, 8'h57};
    property p_shl_a; go && opcode == 8'h48 |=>
        acc_a == {$past(acc_a[6:0]), 1'b0} && f[0] == $past(acc_a[7]); endproperty
    a_shl_a: assert property (p_shl_a) else $error("shift left a wrong");
    property p_shl_d; go && opcode == 8'h59 |=> f[0] == $past(acc_a[7]) &&
        {acc_a, acc_b} == {$past(acc_a[6:0]), $past(acc_b), 1'b0}; endproperty
    a_shl_d: assert property (p_shl_d) else $error("shift left d wrong");
    property p_sar_a; go && opcode == 8'h47 |=>
        acc_a == {$past(acc_a[7]), $past(acc_a[7:1])} && f[0] == $past(acc_a[0]); endproperty
    a_sar_a: assert property (p_sar_a) else $error("shift right a wrong");
    property p_shl_b; go && opcode == 8'h58 |=>
        acc_b == {$past(acc_b[6:0]), 1'b0} && f[0] == $past(acc_b[7]); endproperty
    a_shl_b: assert property (p_shl_b) else $error("shift left b wrong");
    property p_sar_b; go && opcode == 8'h57 |=>
        acc_b == {$past(acc_b[7]), $past(acc_b[7:1])} && f[0] == $past(acc_b[0]); endproperty
    a_sar_b: assert property (p_sar_b) else $error("shift right b wrong");
    property p_nz_a; go && opcode inside {8'h48, 8'h47} |=>
        f[3] == acc_a[7] && f[2] == (acc_a == 8'h00); endproperty
    a_nz_a: assert property (p_nz_a) else $error("n or z wrong after a shift");
    property p_shl_m; go && opcode inside {8'h78, 8'h68} |=> mem_write &&
        mem_data_out == {$past(mem_data_in[6:0]), 1'b0} && f[0] == $past(mem_data_in[7]); endproperty
    a_shl_m: assert property (p_shl_m) else $error("shift left mem wrong");
    property p_sar_m; go && opcode inside {8'h77, 8'h67} |=> mem_write && f[0] == $past(mem_data_in[0])
        && mem_data_out == {$past(mem_data_in[7]), $past(mem_data_in[7:1])}; endproperty
    a_sar_m: assert property (p_sar_m) else $error("shift right mem wrong");
    property p_v; sh |=> f[1] == (f[3] ^ f[0]); endproperty
    a_v: assert property (p_v) else $error("overflow not n xor c");
    property p_keep; sh |=> f[7:4] == $past(f[7:4]); endproperty
    a_keep: assert property (p_keep) else $error("shift changed upper flags");
    property p_bra; go && opcode == 8'h24 |=> pc_load && f == $past(f) && pc_out == $past(pc_in)
        + 16'h0002 + ($past(f[0]) ? 16'h0000 : {{8{$past(rel_offset[7])}}, $past(rel_offset)});
    endproperty
    a_bra: assert property (p_bra) else $error("carry-clear branch wrong");
endmodule
bind scbu_core scbu_core_chk i_scbu_core_chk (
    .core_clk        (core_clk),
    .rst             (rst),
    .exec_valid      (exec_valid),
    .opcode          (opcode),
    .mem_data_in     (mem_data_in),
    .rel_offset      (rel_offset),
    .pc_in           (pc_in),
    .load_valid      (load_valid),
    .acc_a           (acc_a),
    .acc_b           (acc_b),
    .condition_flags (condition_flags),
    .mem_data_out    (mem_data_out),
    .mem_write       (mem_write),
    .pc_out          (pc_out),
    .pc_load         (pc_load)
);

// >>> bench/tb_scbu_core.sv
// testbench: directed scenarios for the shift and carry-branch core
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, s); err_total++; end end
module tb_scbu_core;
    logic        core_clk = 0, rst = 1, ev = 0, lv = 0, mw, pl, ill;
    logic [7:0]  op = 0, mi = 0, rel = 0, la = 0, lb = 0, lf = 0, a, b, f, mo;
    logic [15:0] pc = 0, po;
    int          err_total = 0, num_checks = 0, cyc = 0;
    scbu_core i_scbu_core (.core_clk(core_clk), .rst(rst), .exec_valid(ev), .opcode(op),
        .mem_data_in(mi), .rel_offset(rel), .pc_in(pc), .load_valid(lv), .load_acc_a(la),
        .load_acc_b(lb), .load_flags(lf), .acc_a(a), .acc_b(b), .condition_flags(f),
        .mem_data_out(mo), .mem_write(mw), .pc_out(po), .pc_load(pl), .illegal_op(ill));
    initial forever #5 core_clk = ~core_clk;
    // the whole run needs well under a few hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic ld(input logic [7:0] xa, xb, xf);
        @(posedge core_clk);
        {lv, la, lb, lf} <= {1'b1, xa, xb, xf};
        @(posedge core_clk);
        lv <= 1'b0;
    endtask
    // one idle edge separates requests; outputs are read 1 ns after the taking edge
    task automatic ex(input logic [7:0] o, m, r, input logic [15:0] p);
        @(posedge core_clk);
        {ev, op, mi, rel, pc} <= {1'b1, o, m, r, p};
        @(posedge core_clk);
        ev <= 1'b0;
        #1;
    endtask
    task automatic t_acc();
        ld(8'h81, 8'h00, 8'hA0);
        ex(8'h48, 8'h00, 8'h00, 16'h0000);
        `CHK("shl_a", {8'h02, 8'hA3}, {a, f})
        ex(8'h58, 8'h00, 8'h00, 16'h0000);
        `CHK("shl_b", {8'h02, 8'h00, 8'hA4}, {a, b, f})
        ld(8'h80, 8'hFF, 8'h50);
        ex(8'h59, 8'h00, 8'h00, 16'h0000);
        `CHK("shl_d", {8'h01, 8'hFE, 8'h53}, {a, b, f})
        ld(8'h81, 8'h40, 8'hF0);
        ex(8'h47, 8'h00, 8'h00, 16'h0000);
        `CHK("sar_a", {8'hC0, 8'hF9}, {a, f})
        ex(8'h57, 8'h00, 8'h00, 16'h0000);
        `CHK("sar_b", {8'h20, 8'hF0}, {b, f})
    endtask
    task automatic t_mem();
        ld(8'h11, 8'h22, 8'hD0);
        for (int i = 0; i < 2; i++) begin
            ex(i ? 8'h68 : 8'h78, 8'h80, 8'h00, 16'h0000);
            `CHK("shl_m", {1'b1, 8'h00, 8'hD7}, {mw, mo, f})
            ex(i ? 8'h67 : 8'h77, 8'h81, 8'h00, 16'h0000);
            `CHK("sar_m", {1'b1, 8'hC0, 8'hD9, 8'h11}, {mw, mo, f, a})
        end
    endtask
    task automatic t_bra();
        ld(8'h00, 8'h00, 8'hD0);
        ex(8'h24, 8'h00, 8'hFE, 16'h1000);
        `CHK("bra_taken", {1'b1, 16'h1000, 8'hD0}, {pl, po, f})
        ld(8'h00, 8'h00, 8'hD1);
        ex(8'h24, 8'h00, 8'h7F, 16'h2000);
        `CHK("bra_not", {1'b1, 16'h2002, 8'hD1}, {pl, po, f})
        ld(8'h5A, 8'hA5, 8'hD3);
        ex(8'h00, 8'h00, 8'h00, 16'h0000);
        `CHK("illegal", {1'b1, 8'h5A, 8'hA5, 8'hD3}, {ill, a, b, f})
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        `CHK("reset", {8'h00, 8'h00, 8'hD0, 16'h0000, 8'h00, 3'b000}, {a, b, f, po, mo, pl, mw, ill})
        t_acc();
        t_mem();
        t_bra();
        report_and_stop();
    end
endmodule
